// ### core/mcsk_pkg.sv
package mcsk_pkg;
  // data and program memory widths
  localparam int BYTE_W = 8;
  localparam int PROM_AW = 12;
  localparam int PAGE_W = 4;
  localparam int PROM_W = 15;
  localparam int HIGH_W = PROM_W - BYTE_W;
  // fixed values
  localparam logic [PAGE_W-1:0] LAST_PAGE = 4'hF;
  localparam logic [BYTE_W-1:0] BYTE_ONE = 8'h01;
  localparam logic [BYTE_W-1:0] BYTE_ALL = 8'hFF;
  localparam logic [BYTE_W-1:0] BYTE_NIL = 8'h00;
  localparam logic [BYTE_W-1:0] ACC_RST = 8'h00;
  localparam logic [HIGH_W-1:0] HIGH_RST = 7'h00;
  localparam int NIB_W = 4;

  // operation codes handled by this unit
  typedef enum logic [4:0] {
    OP_SUB_ACC = 5'h00,
    OP_SUB_TO_MEM = 5'h01,
    OP_SUB_IMM = 5'h02,
    OP_SUB_BORROW_TO_MEM = 5'h03,
    OP_DEC_SKIP_IF_NIL = 5'h04,
    OP_DEC_TO_ACC_SKIP_IF_NIL = 5'h05,
    OP_INC_SKIP_IF_NIL = 5'h06,
    OP_INC_TO_ACC_SKIP_IF_NIL = 5'h07,
    OP_SKIP_IF_BIT_ONE = 5'h08,
    OP_SKIP_IF_NIL = 5'h09,
    OP_COPY_SKIP_IF_NIL = 5'h0A,
    OP_SKIP_IF_BIT_NIL = 5'h0B,
    OP_SET_BYTE = 5'h0C,
    OP_SET_BIT = 5'h0D,
    OP_NIBBLE_EXCHANGE = 5'h0E,
    OP_NIBBLE_EXCHANGE_TO_ACC = 5'h0F,
    OP_XOR_ACC = 5'h10,
    OP_EXCLUSIVE_OR_TO_MEM = 5'h11,
    OP_XOR_IMM = 5'h12,
    OP_TABLE_READ_THIS_PAGE = 5'h13,
    OP_TABLE_READ_FINAL_PAGE = 5'h14
  } mcsk_op_t;

  // status flags
  typedef struct packed {
    logic signed_range_flag;
    logic z;
    logic half_byte_carry;
    logic c;
  } mcsk_flags_t;

  localparam mcsk_flags_t FLAGS_RST = 4'h0;

  // one issued instruction
  typedef struct packed {
    mcsk_op_t op;
    logic [2:0] bit_sel;
    logic [BYTE_W-1:0] addr;
    logic [BYTE_W-1:0] imm;
  } mcsk_instr_t;

  // sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_EXEC = 3'b001,
    ST_DUMMY = 3'b010,
    ST_TABLE = 3'b100
  } mcsk_state_t;
endpackage

// ### core/mcsk_sub.sv
`timescale 1ns/1ps
`default_nettype none
module mcsk_sub (
  // operands
  input wire logic [mcsk_pkg::BYTE_W-1:0] a,
  input wire logic [mcsk_pkg::BYTE_W-1:0] b,
  input wire logic cin,
  // result
  output logic [mcsk_pkg::BYTE_W-1:0] res,
  output mcsk_pkg::mcsk_flags_t flags
);
  import mcsk_pkg::*;
  // subtraction as a plus inverted b plus carry-in, so carry out means no borrow
  logic [BYTE_W:0] full;
  logic [NIB_W:0] low;
  always_comb begin
    full = {1'b0, a} + {1'b0, ~b} + {{BYTE_W{1'b0}}, cin};
    low = {1'b0, a[NIB_W-1:0]} + {1'b0, ~b[NIB_W-1:0]} + {{NIB_W{1'b0}}, cin};
    res = full[BYTE_W-1:0];
    flags.c = full[BYTE_W];
    flags.half_byte_carry = low[NIB_W];
    // signed overflow: operands differ in sign and result sign left a
    flags.signed_range_flag = (a[BYTE_W-1] ^ b[BYTE_W-1]) & (res[BYTE_W-1] ^ a[BYTE_W-1]);
    flags.z = (res == BYTE_NIL);
  end
endmodule
`default_nettype wire

// ### core/mcsk_byte.sv
`timescale 1ns/1ps
`default_nettype none
module mcsk_byte (
  // operation and operands
  input wire mcsk_pkg::mcsk_op_t op,
  input wire logic [mcsk_pkg::BYTE_W-1:0] opnd,
  input wire logic [mcsk_pkg::BYTE_W-1:0] acc,
  input wire logic [mcsk_pkg::BYTE_W-1:0] imm,
  input wire logic [2:0] bit_sel,
  // result
  output logic [mcsk_pkg::BYTE_W-1:0] res,
  output logic bit_val
);
  import mcsk_pkg::*;
  // byte results other than subtraction, selected by operation
  always_comb begin
    bit_val = opnd[bit_sel];
    unique case (op)
      OP_DEC_SKIP_IF_NIL, OP_DEC_TO_ACC_SKIP_IF_NIL: res = opnd - BYTE_ONE;
      OP_INC_SKIP_IF_NIL, OP_INC_TO_ACC_SKIP_IF_NIL: res = opnd + BYTE_ONE;
      OP_NIBBLE_EXCHANGE, OP_NIBBLE_EXCHANGE_TO_ACC: res = {opnd[NIB_W-1:0], opnd[BYTE_W-1:NIB_W]};
      OP_XOR_ACC, OP_EXCLUSIVE_OR_TO_MEM: res = acc ^ opnd;
      OP_XOR_IMM: res = acc ^ imm;
      OP_SET_BYTE: res = BYTE_ALL;
      OP_SET_BIT: res = opnd | (BYTE_ONE << bit_sel);
      default: res = opnd;
    endcase
  end
endmodule
`default_nettype wire

// ### core/mcsk_exec.sv
// How it works
// - borrow subtract to memory, flags updated
// - carry clear if negative, set otherwise
// - decrement memory, skip when result zero
// - skip operations take two cycles
// - decrement into accumulator, skip when zero
// - increment memory, skip when result zero
// - increment into accumulator, skip when zero
// - skip when selected bit is one
// - skip when byte zero, change nothing
// - copy byte to accumulator, skip if zero
// - skip when selected bit is zero
// - byte set forces all ones
// - bit set touches only that bit
// - subtract memory to accumulator or memory
// - subtract immediate into accumulator with flags
// - nibble swap to memory or accumulator
// - table read within current page
// - table read within last page
// - xor updates only the zero flag
`timescale 1ns/1ps
`default_nettype none
module mcsk_exec (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // instruction issue
  input wire logic instr_valid,
  input wire mcsk_pkg::mcsk_instr_t instr,
  input wire logic [mcsk_pkg::BYTE_W-1:0] mem_rdata,
  output logic ready,
  // accumulator load from the rest of the core
  input wire logic acc_ld,
  input wire logic [mcsk_pkg::BYTE_W-1:0] acc_ld_data,
  // table read path
  input wire logic [mcsk_pkg::BYTE_W-1:0] table_pointer,
  input wire logic [mcsk_pkg::PAGE_W-1:0] pc_page,
  output logic [mcsk_pkg::PROM_AW-1:0] prom_addr,
  input wire logic [mcsk_pkg::PROM_W-1:0] prom_rdata,
  // data memory write
  output logic mem_we,
  output logic [mcsk_pkg::BYTE_W-1:0] mem_waddr,
  output logic [mcsk_pkg::BYTE_W-1:0] mem_wdata,
  // visible state
  output logic [mcsk_pkg::BYTE_W-1:0] acc,
  output mcsk_pkg::mcsk_flags_t flags,
  output logic [mcsk_pkg::HIGH_W-1:0] table_high_byte_reg,
  output logic skip_next,
  output logic dummy_slot
);
  import mcsk_pkg::*;

  // state registers
  mcsk_state_t state_r;
  mcsk_state_t state_nxt;
  logic [BYTE_W-1:0] acc_r;
  mcsk_flags_t flags_r;
  logic [HIGH_W-1:0] table_high_byte_reg_r;
  logic [PROM_AW-1:0] prom_addr_r;
  logic [BYTE_W-1:0] tab_dest_r; // destination byte of a table read
  logic mem_we_r;
  logic [BYTE_W-1:0] mem_waddr_r;
  logic [BYTE_W-1:0] mem_wdata_r;
  logic skip_r;

  // datapath results
  logic [BYTE_W-1:0] sub_b;
  logic sub_cin;
  logic [BYTE_W-1:0] sub_res;
  mcsk_flags_t sub_flags;
  logic [BYTE_W-1:0] byte_res;
  logic bit_val;

  // decoded controls for the issued instruction
  logic taken;
  logic is_sub;
  logic is_xor;
  logic is_skip;
  logic is_tab;
  logic wr_acc;
  logic wr_mem;
  logic skip_cond;
  logic [BYTE_W-1:0] res;

  assign taken = instr_valid & ready;

  // only the idle state accepts; dummy and table slots stall the issuer
  assign ready = (state_r == ST_EXEC);

  // immediate form takes the byte from the instruction word
  assign sub_b = (instr.op == OP_SUB_IMM) ? instr.imm : mem_rdata;
  // borrow form subtracts the inverted carry; plain forms subtract none
  assign sub_cin = (instr.op == OP_SUB_BORROW_TO_MEM) ? flags_r.c : 1'b1;

  mcsk_sub u_sub (
    .a(acc_r),
    .b(sub_b),
    .cin(sub_cin),
    .res(sub_res),
    .flags(sub_flags)
  );

  mcsk_byte u_byte (
    .op(instr.op),
    .opnd(mem_rdata),
    .acc(acc_r),
    .imm(instr.imm),
    .bit_sel(instr.bit_sel),
    .res(byte_res),
    .bit_val(bit_val)
  );

  // decode: class, destination and skip condition
  always_comb begin
    is_sub = 1'b0;
    is_xor = 1'b0;
    is_skip = 1'b0;
    is_tab = 1'b0;
    wr_acc = 1'b0;
    wr_mem = 1'b0;
    skip_cond = 1'b0;
    res = byte_res;
    unique case (instr.op)
      OP_SUB_ACC, OP_SUB_IMM: begin
        is_sub = 1'b1;
        wr_acc = 1'b1;
        res = sub_res;
      end
      OP_SUB_TO_MEM, OP_SUB_BORROW_TO_MEM: begin
        is_sub = 1'b1;
        wr_mem = 1'b1;
        res = sub_res;
      end
      OP_DEC_SKIP_IF_NIL, OP_INC_SKIP_IF_NIL: begin
        is_skip = 1'b1;
        wr_mem = 1'b1;
        skip_cond = (byte_res == BYTE_NIL);
      end
      OP_DEC_TO_ACC_SKIP_IF_NIL, OP_INC_TO_ACC_SKIP_IF_NIL: begin
        is_skip = 1'b1;
        wr_acc = 1'b1;
        skip_cond = (byte_res == BYTE_NIL);
      end
      OP_SKIP_IF_BIT_ONE: begin
        is_skip = 1'b1;
        skip_cond = bit_val;
      end
      OP_SKIP_IF_BIT_NIL: begin
        is_skip = 1'b1;
        skip_cond = ~bit_val;
      end
      OP_SKIP_IF_NIL: begin
        is_skip = 1'b1; // no write of any kind
        skip_cond = (mem_rdata == BYTE_NIL);
      end
      OP_COPY_SKIP_IF_NIL: begin
        is_skip = 1'b1;
        wr_acc = 1'b1;
        skip_cond = (mem_rdata == BYTE_NIL);
      end
      OP_SET_BYTE, OP_SET_BIT, OP_NIBBLE_EXCHANGE: begin
        wr_mem = 1'b1;
      end
      OP_NIBBLE_EXCHANGE_TO_ACC: begin
        wr_acc = 1'b1; // memory left alone
      end
      OP_XOR_ACC, OP_XOR_IMM: begin
        is_xor = 1'b1;
        wr_acc = 1'b1;
      end
      OP_EXCLUSIVE_OR_TO_MEM: begin
        is_xor = 1'b1;
        wr_mem = 1'b1;
      end
      OP_TABLE_READ_THIS_PAGE, OP_TABLE_READ_FINAL_PAGE: begin
        is_tab = 1'b1;
      end
      default: begin
        // unknown code: acts as no operation
        res = byte_res;
      end
    endcase
  end

  // sequencer: skips get a dummy slot, table reads wait one slot for program memory
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_EXEC: begin
        if (taken && is_skip) begin
          state_nxt = ST_DUMMY;
        end else if (taken && is_tab) begin
          state_nxt = ST_TABLE;
        end
      end
      ST_DUMMY: begin
        state_nxt = ST_EXEC;
      end
      ST_TABLE: begin
        state_nxt = ST_EXEC;
      end
      default: begin
        // illegal one-hot code recovers to idle
        state_nxt = ST_EXEC;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_EXEC;
    end else begin
      state_r <= state_nxt;
    end
  end

  // accumulator: own results win over a load from the core in the same cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_r <= ACC_RST;
    end else if (taken && wr_acc) begin
      acc_r <= res;
    end else if (acc_ld) begin
      acc_r <= acc_ld_data;
    end
  end

  // flags: subtracts set four, xor sets zero only, all else holds
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flags_r <= FLAGS_RST;
    end else if (taken && is_sub) begin
      flags_r <= sub_flags;
    end else if (taken && is_xor) begin
      flags_r.z <= (res == BYTE_NIL);
    end
  end

  // data memory write port, one-cycle pulse after the issue or table slot
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_we_r <= 1'b0;
      mem_waddr_r <= BYTE_NIL;
      mem_wdata_r <= BYTE_NIL;
    end else if (state_r == ST_TABLE) begin
      mem_we_r <= 1'b1; // low byte of program word
      mem_waddr_r <= tab_dest_r;
      mem_wdata_r <= prom_rdata[BYTE_W-1:0];
    end else begin
      mem_we_r <= taken & wr_mem;
      mem_waddr_r <= instr.addr;
      mem_wdata_r <= res;
    end
  end

  // skip indication lives in the dummy slot only
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      skip_r <= 1'b0;
    end else begin
      skip_r <= taken & is_skip & skip_cond;
    end
  end

  // table address: pointer forms the low part, page picks the high part
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prom_addr_r <= {PROM_AW{1'b0}};
      tab_dest_r <= BYTE_NIL;
    end else if (taken && is_tab) begin
      tab_dest_r <= instr.addr;
      if (instr.op == OP_TABLE_READ_FINAL_PAGE) begin
        prom_addr_r <= {LAST_PAGE, table_pointer};
      end else begin
        prom_addr_r <= {pc_page, table_pointer};
      end
    end
  end

  // high part of the program word, sampled at the end of the table slot
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      table_high_byte_reg_r <= HIGH_RST;
    end else if (state_r == ST_TABLE) begin
      table_high_byte_reg_r <= prom_rdata[PROM_W-1:BYTE_W];
    end
  end

  // outputs
  assign acc = acc_r;
  assign flags = flags_r;
  assign table_high_byte_reg = table_high_byte_reg_r;
  assign prom_addr = prom_addr_r;
  assign mem_we = mem_we_r;
  assign mem_waddr = mem_waddr_r;
  assign mem_wdata = mem_wdata_r;
  assign skip_next = skip_r;
  assign dummy_slot = (state_r == ST_DUMMY);

  // checks
  sequence skip_issue_s;
    taken && is_skip;
  endsequence
  sequence dummy_then_idle_s;
    dummy_slot && !ready ##1 ready;
  endsequence

  skip_two_cycles_a: assert property (@(posedge clk) disable iff (!reset_n)
    skip_issue_s |=> dummy_then_idle_s)
    else $error("skip did not take two cycles");

  sub_carry_a: assert property (@(posedge clk) disable iff (!reset_n)
    taken && instr.op == OP_SUB_ACC |=>
      flags.c == ($past(acc_r) >= $past(mem_rdata)) && acc == $past(acc_r) - $past(mem_rdata))
    else $error("subtract carry or result wrong");

  borrow_mem_a: assert property (@(posedge clk) disable iff (!reset_n)
    taken && instr.op == OP_SUB_BORROW_TO_MEM |=> mem_we &&
      mem_wdata == $past(acc_r) - $past(mem_rdata) - {{BYTE_W-1{1'b0}}, ~$past(flags_r.c)})
    else $error("borrow subtract to memory wrong");

  dec_skip_a: assert property (@(posedge clk) disable iff (!reset_n)
    taken && instr.op == OP_DEC_SKIP_IF_NIL |=> mem_we &&
      mem_wdata == $past(mem_rdata) - BYTE_ONE && skip_next == ($past(mem_rdata) == BYTE_ONE))
    else $error("decrement skip wrong");

  inc_acc_a: assert property (@(posedge clk) disable iff (!reset_n)
    taken && instr.op == OP_INC_TO_ACC_SKIP_IF_NIL |=> !mem_we &&
      acc == $past(mem_rdata) + BYTE_ONE && skip_next == ($past(mem_rdata) == BYTE_ALL))
    else $error("increment to accumulator wrong");

  nil_quiet_a: assert property (@(posedge clk) disable iff (!reset_n)
    // a core load in the issue cycle may still move the accumulator, so leave it out
    taken && instr.op == OP_SKIP_IF_NIL && !acc_ld |=> !mem_we && $stable(acc) && $stable(flags))
    else $error("zero skip changed state");

  bit_set_a: assert property (@(posedge clk) disable iff (!reset_n)
    taken && instr.op == OP_SET_BIT |=> mem_we &&
      mem_wdata == ($past(mem_rdata) | (BYTE_ONE << $past(instr.bit_sel))) && $stable(flags))
    else $error("bit set wrong");

  xor_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
    taken && instr.op == OP_XOR_ACC |=> acc == ($past(acc_r) ^ $past(mem_rdata)) &&
      flags.z == (acc == BYTE_NIL) && flags.c == $past(flags_r.c))
    else $error("xor result or flags wrong");

  table_final_a: assert property (@(posedge clk) disable iff (!reset_n)
    taken && instr.op == OP_TABLE_READ_FINAL_PAGE |=>
      prom_addr[PROM_AW-1:BYTE_W] == LAST_PAGE && !ready ##1 mem_we)
    else $error("final page table read wrong");
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// one compare, counted, reported at once
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin errors++; \
  $display("MISMATCH at %0t: got %h expected %h", $time, (got), (exp)); end end
module tb_top;
  import mcsk_pkg::*;
  logic clk;
  logic reset_n;
  logic instr_valid;
  mcsk_instr_t instr;
  logic [BYTE_W-1:0] mem_rdata;
  logic ready;
  logic acc_ld;
  logic [BYTE_W-1:0] acc_ld_data;
  logic [BYTE_W-1:0] table_pointer;
  logic [PAGE_W-1:0] pc_page;
  logic [PROM_AW-1:0] prom_addr;
  logic [PROM_W-1:0] prom_rdata;
  logic mem_we;
  logic [BYTE_W-1:0] mem_waddr;
  logic [BYTE_W-1:0] mem_wdata;
  logic [BYTE_W-1:0] acc;
  mcsk_flags_t flags;
  logic [HIGH_W-1:0] table_high_byte_reg;
  logic skip_next;
  logic dummy_slot;
  int errors;
  int checks;
  logic [BYTE_W-1:0] cur_addr;  // moved on every issue so a stale address shows up
  logic [3:0] ef;  // flags the bench expects, tracked op by op

  mcsk_exec DUT (
    .clk(clk), .reset_n(reset_n), .instr_valid(instr_valid), .instr(instr),
    .mem_rdata(mem_rdata), .ready(ready), .acc_ld(acc_ld), .acc_ld_data(acc_ld_data),
    .table_pointer(table_pointer), .pc_page(pc_page), .prom_addr(prom_addr),
    .prom_rdata(prom_rdata), .mem_we(mem_we), .mem_waddr(mem_waddr), .mem_wdata(mem_wdata),
    .acc(acc), .flags(flags), .table_high_byte_reg(table_high_byte_reg),
    .skip_next(skip_next), .dummy_slot(dummy_slot)
  );

  // 40 ns period
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // verdict, reached from the main sequence or the watchdog
  task automatic wrap_up;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // one issue: raised after an edge, taken at the next, answer read 1 ns later
  task automatic issue(input mcsk_op_t op, input logic [7:0] m, input logic [7:0] im,
      input logic [2:0] bs);
    @(posedge clk);
    cur_addr = cur_addr + 8'h0B;
    instr_valid <= 1'b1;
    instr <= '{op: op, bit_sel: bs, addr: cur_addr, imm: im};
    mem_rdata <= m;
    @(posedge clk);
    instr_valid <= 1'b0;
    mem_rdata <= ~m;  // byte is no longer presented once taken
    #1;
  endtask

  // core-side accumulator load
  task automatic set_acc(input logic [7:0] v);
    @(posedge clk);
    acc_ld <= 1'b1;
    acc_ld_data <= v;
    @(posedge clk);
    acc_ld <= 1'b0;
    #1;
    `CHK(acc, v)
  endtask

  // single-cycle op: write pulse, accumulator and flags
  task automatic do_op(input mcsk_op_t op, input logic [7:0] m, input logic [7:0] im,
      input logic [2:0] bs, input logic we, input logic [7:0] wd, input logic [7:0] av,
      input logic [3:0] fv);
    issue(op, m, im, bs);
    ef = fv;
    `CHK(mem_we, we)
    if (we) begin
      `CHK(mem_wdata, wd)
      `CHK(mem_waddr, cur_addr)
    end
    `CHK(acc, av)
    `CHK(flags, ef)
    `CHK(ready, 1'b1)
  endtask

  // skip op: dummy slot, refused issue inside it, flags untouched
  task automatic do_skip(input mcsk_op_t op, input logic [7:0] m, input logic [2:0] bs,
      input logic sk, input logic we, input logic [7:0] wd, input logic [7:0] av);
    issue(op, m, 8'h00, bs);
    `CHK(skip_next, sk)
    `CHK(dummy_slot, 1'b1)
    `CHK(ready, 1'b0)
    `CHK(mem_we, we)
    if (we) begin
      `CHK(mem_wdata, wd)
      `CHK(mem_waddr, cur_addr)
    end
    `CHK(acc, av)
    `CHK(flags, ef)
    instr_valid <= 1'b1;  // offered while busy, must be ignored
    instr <= '{op: OP_SET_BYTE, bit_sel: 3'h0, addr: 8'hEE, imm: 8'h00};
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
    `CHK(dummy_slot, 1'b0)
    `CHK(skip_next, 1'b0)
    `CHK(mem_we, 1'b0)
    `CHK(ready, 1'b1)
  endtask

  // reset values while reset is held
  task automatic check_reset;
    #1;
    `CHK(acc, 8'h00)
    `CHK(flags, 4'h0)
    `CHK(table_high_byte_reg, 7'h00)
    `CHK(prom_addr, 12'h000)
    `CHK(mem_we, 1'b0)
    `CHK(skip_next, 1'b0)
    `CHK(dummy_slot, 1'b0)
    `CHK(ready, 1'b1)
  endtask

  // flags packed as {signed_range, zero, half_byte_carry, carry}
  task automatic run_subtract;
    set_acc(8'h10);
    do_op(OP_SUB_ACC, 8'h20, 8'h00, 3'h0, 1'b0, 8'h00, 8'hF0, 4'h2);
    do_op(OP_SUB_IMM, 8'h00, 8'h70, 3'h0, 1'b0, 8'h00, 8'h80, 4'h3);
    do_op(OP_SUB_IMM, 8'h00, 8'h01, 3'h0, 1'b0, 8'h00, 8'h7F, 4'h9);
    do_op(OP_SUB_TO_MEM, 8'h7F, 8'h00, 3'h0, 1'b1, 8'h00, 8'h7F, 4'h7);
    do_op(OP_SUB_BORROW_TO_MEM, 8'h0F, 8'h00, 3'h0, 1'b1, 8'h70, 8'h7F, 4'h3);
    set_acc(8'h00);
    do_op(OP_SUB_ACC, 8'h01, 8'h00, 3'h0, 1'b0, 8'h00, 8'hFF, 4'h0);
    set_acc(8'h05);
    do_op(OP_SUB_BORROW_TO_MEM, 8'h04, 8'h00, 3'h0, 1'b1, 8'h00, 8'h05, 4'h7);
  endtask

  // every skip op, taken and not taken
  task automatic run_skips;
    set_acc(8'h55);
    do_skip(OP_DEC_SKIP_IF_NIL, 8'h01, 3'h0, 1'b1, 1'b1, 8'h00, 8'h55);
    do_skip(OP_DEC_SKIP_IF_NIL, 8'h00, 3'h0, 1'b0, 1'b1, 8'hFF, 8'h55);
    do_skip(OP_DEC_TO_ACC_SKIP_IF_NIL, 8'h01, 3'h0, 1'b1, 1'b0, 8'h00, 8'h00);
    do_skip(OP_DEC_TO_ACC_SKIP_IF_NIL, 8'h80, 3'h0, 1'b0, 1'b0, 8'h00, 8'h7F);
    do_skip(OP_INC_SKIP_IF_NIL, 8'hFF, 3'h0, 1'b1, 1'b1, 8'h00, 8'h7F);
    do_skip(OP_INC_SKIP_IF_NIL, 8'h7F, 3'h0, 1'b0, 1'b1, 8'h80, 8'h7F);
    do_skip(OP_INC_TO_ACC_SKIP_IF_NIL, 8'hFF, 3'h0, 1'b1, 1'b0, 8'h00, 8'h00);
    do_skip(OP_INC_TO_ACC_SKIP_IF_NIL, 8'h0F, 3'h0, 1'b0, 1'b0, 8'h00, 8'h10);
    do_skip(OP_SKIP_IF_BIT_ONE, 8'h08, 3'h3, 1'b1, 1'b0, 8'h00, 8'h10);
    do_skip(OP_SKIP_IF_BIT_ONE, 8'hF7, 3'h3, 1'b0, 1'b0, 8'h00, 8'h10);
    do_skip(OP_SKIP_IF_NIL, 8'h00, 3'h0, 1'b1, 1'b0, 8'h00, 8'h10);
    do_skip(OP_SKIP_IF_NIL, 8'h01, 3'h0, 1'b0, 1'b0, 8'h00, 8'h10);
    do_skip(OP_COPY_SKIP_IF_NIL, 8'h00, 3'h0, 1'b1, 1'b0, 8'h00, 8'h00);
    do_skip(OP_COPY_SKIP_IF_NIL, 8'hA5, 3'h0, 1'b0, 1'b0, 8'h00, 8'hA5);
    do_skip(OP_SKIP_IF_BIT_NIL, 8'hFE, 3'h0, 1'b1, 1'b0, 8'h00, 8'hA5);
    do_skip(OP_SKIP_IF_BIT_NIL, 8'h7F, 3'h7, 1'b1, 1'b0, 8'h00, 8'hA5);
    do_skip(OP_SKIP_IF_BIT_NIL, 8'h01, 3'h0, 1'b0, 1'b0, 8'h00, 8'hA5);
  endtask

  // set, bit set, nibble swap, xor; flags tracked in ef
  task automatic run_logic;
    do_op(OP_SET_BYTE, 8'h5A, 8'h00, 3'h0, 1'b1, 8'hFF, 8'hA5, ef);
    do_op(OP_SET_BIT, 8'h00, 8'h00, 3'h7, 1'b1, 8'h80, 8'hA5, ef);
    do_op(OP_SET_BIT, 8'hF0, 8'h00, 3'h2, 1'b1, 8'hF4, 8'hA5, ef);
    do_op(OP_NIBBLE_EXCHANGE, 8'h3C, 8'h00, 3'h0, 1'b1, 8'hC3, 8'hA5, ef);
    do_op(OP_NIBBLE_EXCHANGE_TO_ACC, 8'hA1, 8'h00, 3'h0, 1'b0, 8'h00, 8'h1A, ef);
    do_op(OP_XOR_IMM, 8'h00, 8'h0F, 3'h0, 1'b0, 8'h00, 8'h15, 4'h3);
    do_op(OP_EXCLUSIVE_OR_TO_MEM, 8'h15, 8'h00, 3'h0, 1'b1, 8'h00, 8'h15, 4'h7);
    do_op(OP_XOR_ACC, 8'hFF, 8'h00, 3'h0, 1'b0, 8'h00, 8'hEA, 4'h3);
  endtask

  // table read: address in slot one, split write in slot two
  task automatic tbl_read(input mcsk_op_t op, input logic [7:0] ptr, input logic [14:0] w,
      input logic [11:0] pa);
    @(posedge clk);
    pc_page <= 4'h5;
    table_pointer <= ptr;
    prom_rdata <= ~w;  // wrong word until the table slot, so an early sample shows up
    issue(op, 8'h00, 8'h00, 3'h0);
    prom_rdata <= w;  // program memory answers inside the table slot
    `CHK(prom_addr, pa)
    `CHK(ready, 1'b0)
    @(posedge clk);
    #1;
    `CHK(mem_we, 1'b1)
    `CHK(mem_waddr, cur_addr)
    `CHK(mem_wdata, w[7:0])
    `CHK(table_high_byte_reg, w[14:8])
    `CHK(flags, ef)
  endtask

  // main sequence
  initial begin
    reset_n = 1'b0;
    instr_valid = 1'b0;
    instr = '0;
    mem_rdata = 8'h00;
    acc_ld = 1'b0;
    acc_ld_data = 8'h00;
    table_pointer = 8'h00;
    pc_page = 4'h0;
    prom_rdata = 15'h0000;
    errors = 0;
    checks = 0;
    cur_addr = 8'h10;
    ef = 4'h0;
    repeat (12) @(posedge clk);
    check_reset();
    @(posedge clk);
    reset_n <= 1'b1;
    run_subtract();
    run_skips();
    run_logic();
    tbl_read(OP_TABLE_READ_THIS_PAGE, 8'hC3, 15'h5AB6, 12'h5C3);
    tbl_read(OP_TABLE_READ_FINAL_PAGE, 8'h07, 15'h2301, 12'hF07);
    repeat (4) @(posedge clk);
    wrap_up();
  end

  // the whole run is about 115 cycles; cut a hang far beyond that
  initial begin
    #(40 * 5000);
    errors++;
    wrap_up();
  end
endmodule
`default_nettype wire
